// ===== src/acs_slave.sv
// Two-wire serial control slave: framing, acknowledge, address change, coefficient capture
// ==========================================================
// Summary of operation
// - Address and data bytes move as eight bits, most significant first.
// - The receiver of each byte acknowledges in the following clock period.
// - Data falling with clock high starts; data rising with clock high stops.
// - Data line changes only while the clock line is low.
// - Device holds data low through the whole acknowledge period when addressed.
// - Any number of bytes may pass between one start and one stop.
// - Slave address is 0011010 with strap low, 0011011 with strap high.
// - Writing key F9A5A5 to unlock register arms an address change.
// - After unlock, low seven bits of the word written to new-address register become the address.
// - Gain coefficients are 26-bit signed fixed point, three integer bits.
// - Top coefficient bit set means negative, two's complement value.
// - Bits above the 26-bit field in a coefficient word are unused.
`timescale 1ns/1ps
module acs_slave (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        ce,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe_n,
    input  wire logic                        addr_sel_pin,
    input  wire logic [acs_pkg::BYTE_W-1:0]  rd_byte,
    output logic [acs_pkg::SUB_W-1:0]        rd_sub,
    output logic [acs_pkg::SUB_W-1:0]        rd_idx,
    output acs_pkg::acs_wr_s                 wr,
    output logic                             wr_stb,
    output logic [acs_pkg::ADDR_W-1:0]       slave_addr,
    output logic [acs_pkg::COEF_W-1:0]       coef,
    output logic                             coef_neg,
    output logic [acs_pkg::COEF_W-1:0]       coef_mag,
    output logic                             coef_stb,
    output logic                             addr_armed
);
    logic [2:0]                  pins_s;
    logic                        scl_s, sda_s, pin_s;
    logic                        scl_d_r, sda_d_r;
    logic                        scl_rise, scl_fall, start_det, stop_det;
    acs_pkg::acs_state_e         st_r;
    logic [acs_pkg::CNT_W-1:0]   cnt_r;
    logic [acs_pkg::BYTE_W-1:0]  shift_r, tx_r;
    logic                        rx_done, addr_hit, strap_done_r;
    logic [1:0]                  strap_wait_r;
    logic [acs_pkg::SUB_W-1:0]   sub_r;
    logic [acs_pkg::WORD_W-1:0]  word_r, word_nxt;
    logic [2:0]                  wcnt_r;
    logic                        writing_r;

    // Two's complement magnitude of a 3.23 coefficient
    function automatic logic [acs_pkg::COEF_W-1:0] coef_abs(input logic [acs_pkg::COEF_W-1:0] c);
        coef_abs = c[acs_pkg::COEF_W-1] ? (~c + 1'b1) : c;
    endfunction : coef_abs

    // ==========================================================
    // Pin synchronisers and line event detection
    acs_sync #(.W(3)) u_sync (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .d    ({scl_in, sda_in, addr_sel_pin}),
        .q    (pins_s)
    );
    assign {scl_s, sda_s, pin_s} = pins_s;

    // Delayed copies of the synchronised lines for edge finding
    always_ff @(posedge clk) begin
        if (srst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (ce) begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Data edges with clock high are frame markers, not bits
    assign scl_rise  = ce & scl_s & ~scl_d_r;
    assign scl_fall  = ce & ~scl_s & scl_d_r;
    assign start_det = ce & scl_s & scl_d_r & ~sda_s & sda_d_r;
    assign stop_det  = ce & scl_s & scl_d_r & sda_s & ~sda_d_r;
    assign rx_done   = scl_fall & (cnt_r == acs_pkg::RX_BITS);
    assign addr_hit  = (shift_r[acs_pkg::BYTE_W-1:1] == slave_addr);

    // ==========================================================
    // Protocol state machine
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r    <= acs_pkg::ST_IDLE;
            cnt_r   <= '0;
            shift_r <= '0;
            tx_r    <= '1;
        end else if (ce) begin
            if (start_det) begin
                st_r  <= acs_pkg::ST_ADDR;
                cnt_r <= '0;
            end else if (stop_det) begin
                st_r  <= acs_pkg::ST_IDLE;
                cnt_r <= '0;
            end else begin
                case (st_r)
                    acs_pkg::ST_ADDR, acs_pkg::ST_SUB, acs_pkg::ST_WDATA: begin
                        // Sample on rising clock, MSB arrives first
                        if (scl_rise) begin
                            shift_r <= {shift_r[acs_pkg::BYTE_W-2:0], sda_s};
                            cnt_r   <= cnt_r + 1'b1;
                        end else if (rx_done) begin
                            cnt_r <= '0;
                            case (st_r)
                                acs_pkg::ST_ADDR: st_r <= acs_pkg::ST_AACK;
                                acs_pkg::ST_SUB:  st_r <= acs_pkg::ST_SACK;
                                default:          st_r <= acs_pkg::ST_WACK;
                            endcase
                        end
                    end
                    acs_pkg::ST_AACK: begin
                        if (scl_fall) begin
                            if (!addr_hit) begin
                                st_r <= acs_pkg::ST_IDLE;
                            end else if (shift_r[0] == acs_pkg::RW_READ) begin
                                st_r <= acs_pkg::ST_RDATA;
                                tx_r <= rd_byte;
                            end else begin
                                st_r <= acs_pkg::ST_SUB;
                            end
                        end
                    end
                    acs_pkg::ST_SACK, acs_pkg::ST_WACK: begin
                        // No byte limit: every acked byte leads to another
                        if (scl_fall) begin
                            st_r <= acs_pkg::ST_WDATA;
                        end
                    end
                    acs_pkg::ST_RDATA: begin
                        // Shift the next bit out just after clock falls
                        if (scl_fall) begin
                            if (cnt_r == acs_pkg::TX_LAST) begin
                                st_r  <= acs_pkg::ST_MACK;
                                cnt_r <= '0;
                                tx_r  <= '1;
                            end else begin
                                tx_r  <= {tx_r[acs_pkg::BYTE_W-2:0], 1'b1};
                                cnt_r <= cnt_r + 1'b1;
                            end
                        end
                    end
                    acs_pkg::ST_MACK: begin
                        // Master acknowledge continues the read, NACK ends it
                        if (scl_rise) begin
                            shift_r[0] <= sda_s;
                        end else if (scl_fall) begin
                            if (shift_r[0]) begin
                                st_r <= acs_pkg::ST_IDLE;
                            end else begin
                                st_r <= acs_pkg::ST_RDATA;
                                tx_r <= rd_byte;
                            end
                        end
                    end
                    default: st_r <= acs_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Open-drain data driver; one cycle after the state, so edges fall in clock-low time
    always_ff @(posedge clk) begin
        if (srst) begin
            sda_oe_n <= 1'b1;
            sda_out  <= 1'b0;
        end else if (ce) begin
            sda_out <= 1'b0;
            case (st_r)
                acs_pkg::ST_AACK:  sda_oe_n <= ~addr_hit;
                acs_pkg::ST_SACK,
                acs_pkg::ST_WACK:  sda_oe_n <= 1'b0;
                acs_pkg::ST_RDATA: sda_oe_n <= tx_r[acs_pkg::BYTE_W-1];
                default:           sda_oe_n <= 1'b1;
            endcase
        end
    end

    // ==========================================================
    // Subaddress, word packing and write strobes
    assign word_nxt = {word_r[acs_pkg::WORD_W-acs_pkg::BYTE_W-1:0], shift_r};

    always_ff @(posedge clk) begin
        if (srst) begin
            sub_r     <= '0;
            word_r    <= '0;
            wcnt_r    <= '0;
            writing_r <= 1'b0;
            wr_stb    <= 1'b0;
            wr        <= '0;
            rd_sub    <= '0;
            rd_idx    <= '0;
        end else if (ce) begin
            wr_stb <= 1'b0;
            if (start_det || stop_det) begin
                // A partial word (byte-wide register) is flushed by the frame end
                if (writing_r && wcnt_r != '0) begin
                    wr_stb <= 1'b1;
                    wr     <= '{sub: sub_r, data: word_r, nbytes: wcnt_r};
                end
                writing_r <= 1'b0;
                wcnt_r    <= '0;
                word_r    <= '0;
            end else if (rx_done && st_r == acs_pkg::ST_SUB) begin
                sub_r     <= shift_r;
                writing_r <= 1'b1;
            end else if (rx_done && st_r == acs_pkg::ST_WDATA) begin
                if (wcnt_r == acs_pkg::WORD_LAST) begin
                    wr_stb <= 1'b1;
                    wr     <= '{sub: sub_r, data: word_nxt, nbytes: acs_pkg::WORD_BYTES};
                    sub_r  <= sub_r + 1'b1;
                    wcnt_r <= '0;
                    word_r <= '0;
                end else begin
                    word_r <= word_nxt;
                    wcnt_r <= wcnt_r + 1'b1;
                end
            end else if (scl_fall && st_r == acs_pkg::ST_AACK && addr_hit
                         && shift_r[0] == acs_pkg::RW_READ) begin
                rd_sub <= sub_r;
                rd_idx <= '0;
            end else if (scl_fall && st_r == acs_pkg::ST_MACK && !shift_r[0]) begin
                rd_idx <= rd_idx + 1'b1;
            end
        end
    end

    // ==========================================================
    // Strap sampling and runtime address change
    always_ff @(posedge clk) begin
        if (srst) begin
            strap_wait_r <= '0;
            strap_done_r <= 1'b0;
            slave_addr   <= acs_pkg::SLAVE_ADDR_BASE;
            addr_armed   <= 1'b0;
        end else if (ce) begin
            // Two enabled edges first, so the synchroniser's reset value is flushed out
            strap_wait_r <= {strap_wait_r[0], 1'b1};
            if (!strap_done_r) begin
                if (strap_wait_r[1]) begin
                    strap_done_r <= 1'b1;
                    slave_addr   <= acs_pkg::SLAVE_ADDR_BASE | {6'h00, pin_s};
                end
            end else if (wr_stb && wr.nbytes == acs_pkg::WORD_BYTES) begin
                if (wr.sub == acs_pkg::SUB_UNLOCK) begin
                    addr_armed <= (wr.data[23:0] == acs_pkg::UNLOCK_KEY);
                end else if (wr.sub == acs_pkg::SUB_NEW_ADDR && addr_armed) begin
                    slave_addr <= wr.data[acs_pkg::ADDR_W-1:0];
                    addr_armed <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Coefficient capture; word upper bits are discarded
    always_ff @(posedge clk) begin
        if (srst) begin
            coef     <= '0;
            coef_neg <= 1'b0;
            coef_mag <= '0;
            coef_stb <= 1'b0;
        end else if (ce) begin
            coef_stb <= 1'b0;
            if (wr_stb && wr.nbytes == acs_pkg::WORD_BYTES
                && wr.sub != acs_pkg::SUB_UNLOCK && wr.sub != acs_pkg::SUB_NEW_ADDR) begin
                coef     <= wr.data[acs_pkg::COEF_W-1:0];
                coef_neg <= wr.data[acs_pkg::COEF_W-1];
                coef_mag <= coef_abs(wr.data[acs_pkg::COEF_W-1:0]);
                coef_stb <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    chk_start_frame: assert property (@(posedge clk) disable iff (srst)
        start_det |=> st_r == acs_pkg::ST_ADDR)
        else $error("start did not open address phase");
    chk_stop_idle: assert property (@(posedge clk) disable iff (srst)
        (stop_det && !start_det) |=> st_r == acs_pkg::ST_IDLE)
        else $error("stop did not return to idle");
    chk_sda_scl_high: assert property (@(posedge clk) disable iff (srst)
        (scl_s && $past(scl_s) && $past(scl_s, 2)) |-> $stable(sda_oe_n))
        else $error("data drive changed while clock high");
    chk_ack_whole: assert property (@(posedge clk) disable iff (srst)
        (st_r == acs_pkg::ST_SACK && $past(st_r) == acs_pkg::ST_SACK) |-> !sda_oe_n)
        else $error("acknowledge not held low");
    chk_foreign_nack: assert property (@(posedge clk) disable iff (srst)
        (ce && st_r == acs_pkg::ST_AACK && !addr_hit) |=> sda_oe_n)
        else $error("foreign address acknowledged");
    chk_bit_bound: assert property (@(posedge clk) disable iff (srst)
        cnt_r <= acs_pkg::RX_BITS)
        else $error("bit counter beyond a byte");
    chk_unlock_arm: assert property (@(posedge clk) disable iff (srst)
        (ce && strap_done_r && wr_stb && wr.nbytes == acs_pkg::WORD_BYTES
         && wr.sub == acs_pkg::SUB_UNLOCK) |=> addr_armed == ($past(wr.data[23:0]) == acs_pkg::UNLOCK_KEY))
        else $error("unlock key handling wrong");
    chk_addr_take: assert property (@(posedge clk) disable iff (srst)
        (ce && strap_done_r && addr_armed && wr_stb && wr.nbytes == acs_pkg::WORD_BYTES
         && wr.sub == acs_pkg::SUB_NEW_ADDR) |=> slave_addr == $past(wr.data[6:0]) && !addr_armed)
        else $error("new address not adopted");
    chk_coef_field: assert property (@(posedge clk) disable iff (srst)
        $rose(coef_stb) |-> coef == $past(wr.data[acs_pkg::COEF_W-1:0])
                            && coef_neg == $past(wr.data[acs_pkg::COEF_W-1]))
        else $error("coefficient field wrong");
    chk_strap_addr: assert property (@(posedge clk) disable iff (srst)
        $rose(strap_done_r) |-> slave_addr == (acs_pkg::SLAVE_ADDR_BASE | {6'h00, $past(pin_s)}))
        else $error("strap address wrong");

endmodule : acs_slave

// ===== src/acs_pkg.sv
// Constants, state codes and carrier types of the amplifier control serial slave
package acs_pkg;

    // ==========================================================
    // Link framing
    localparam int             BYTE_W         = 8;
    localparam int             ADDR_W         = 7;
    localparam int             SUB_W          = 8;
    localparam int             WORD_W         = 32;
    localparam int             COEF_W         = 26;
    localparam int             CNT_W          = 4;
    localparam logic [3:0]     RX_BITS        = 4'h8;
    localparam logic [3:0]     TX_LAST        = 4'h7;
    localparam logic [2:0]     WORD_BYTES     = 3'h4;
    localparam logic [2:0]     WORD_LAST      = 3'h3;
    localparam logic           RW_READ        = 1'b1;

    // ==========================================================
    // Slave address and address change
    localparam logic [6:0]     SLAVE_ADDR_BASE = 7'h1A;
    localparam logic [7:0]     SUB_UNLOCK      = 8'hF8;
    localparam logic [7:0]     SUB_NEW_ADDR    = 8'hF9;
    localparam logic [23:0]    UNLOCK_KEY      = 24'hF9_A5A5;

    // ==========================================================
    // Protocol states, one-hot
    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_ADDR  = 9'h002,
        ST_AACK  = 9'h004,
        ST_SUB   = 9'h008,
        ST_SACK  = 9'h010,
        ST_WDATA = 9'h020,
        ST_WACK  = 9'h040,
        ST_RDATA = 9'h080,
        ST_MACK  = 9'h100
    } acs_state_e;

    // ==========================================================
    // Register write carried to the amplifier core
    typedef struct packed {
        logic [SUB_W-1:0]  sub;
        logic [WORD_W-1:0] data;
        logic [2:0]        nbytes;
    } acs_wr_s;

endpackage : acs_pkg

// ===== src/acs_sync.sv
// Two-flop synchroniser for pin inputs, frozen by the clock enable
`timescale 1ns/1ps
module acs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // ==========================================================
    // Synchroniser: first stage feeds only the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= '1;
            q      <= '1;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : acs_sync

// ===== dv/acs_master.sv
// Bus master model that drives the two-wire control link
`timescale 1ns/1ps
module acs_master (
    input  wire logic clk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_drv
);
    // Extra low-phase cycles for a slow master; zero keeps the 320 ns bit period
    int stretch = 0;

    // ==========================================================
    // Idle bus: both lines released, clock stands still
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Start or repeated start: data falls while the clock is high
    task automatic start_cond();
        if (scl === 1'b0) begin
            sda_drv = 1'b1;
            tick(5);
            scl = 1'b1;
            tick(4);
        end
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask : start_cond

    // Stop: data rises while the clock is high, then the bus rests
    task automatic stop_cond();
        tick(1);
        sda_drv = 1'b0;
        tick(5);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(8);
    endtask : stop_cond

    // One bit: data moves in the low phase only, sampled late in the high phase
    task automatic xfer_bit(input logic b, output logic r);
        tick(1);
        sda_drv = b;
        tick(4 + stretch);
        scl = 1'b1;
        tick(3);
        r   = sda_in;
        scl = 1'b0;
    endtask : xfer_bit

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    // Every read byte but the last one is acknowledged
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
        xfer_bit(last, r);
    endtask : get_byte
endmodule : acs_master

// ===== dv/acs_slave_bench.sv
// Self-checking bench of the serial control slave
`timescale 1ns/1ps
module acs_slave_bench;
    logic             clk = 1'b0;
    logic             srst = 1'b1;
    logic             addr_sel_pin = 1'b0;
    logic [7:0]       rd_val = 8'h00;
    logic [7:0]       rd_sub;
    logic [7:0]       rd_idx;
    logic             ce_en = 1'b1;
    logic             scl;
    logic             m_sda;
    logic             sda_out;
    logic             sda_oe_n;
    acs_pkg::acs_wr_s wr;
    logic             wr_stb;
    logic [6:0]       slave_addr;
    logic [25:0]      coef;
    logic             coef_neg;
    logic [25:0]      coef_mag;
    logic             coef_stb;
    logic             addr_armed;
    logic [31:0]      rng = 32'h45ac_a29e;
    int               num_errors = 0;
    int               comparisons = 0;
    logic [7:0]       dq[$];
    acs_pkg::acs_wr_s ex[$];
    acs_pkg::acs_wr_s wq[$];
    logic [25:0]      cx[$];
    // Open-drain data line with pull-up: low while either party pulls
    wire              sda_line = m_sda & (sda_oe_n | sda_out);

    always #20 clk = ~clk;

    acs_slave i_dut (.clk(clk), .srst(srst), .ce(ce_en), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel_pin(addr_sel_pin), .rd_byte(rd_val),
        .rd_sub(rd_sub), .rd_idx(rd_idx), .wr(wr), .wr_stb(wr_stb), .slave_addr(slave_addr),
        .coef(coef),
        .coef_neg(coef_neg), .coef_mag(coef_mag), .coef_stb(coef_stb), .addr_armed(addr_armed));
    acs_master i_master (.clk(clk), .sda_in(sda_line), .scl(scl), .sda_drv(m_sda));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    function automatic logic [25:0] mag(input logic [25:0] c);
        return c[25] ? ~c + 26'h000_0001 : c;
    endfunction : mag

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic do_reset(input logic pin);
        @(negedge clk);
        srst         = 1'b1;
        addr_sel_pin = pin;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        repeat (6) @(negedge clk);
    endtask : do_reset

    // Record strobed writes; each coefficient is checked against the queued word
    always @(negedge clk) begin
        if (wr_stb === 1'b1) wq.push_back(wr);
        if (coef_stb === 1'b1) begin
            if (cx.size() == 0) begin
                check(1'b1, 1'b0);
            end else begin
                check(coef, cx[0]);
                check(coef_neg, cx[0][25]);
                check(coef_mag, mag(cx[0]));
                void'(cx.pop_front());
            end
        end
    end

    // Write frame of the bytes in dq; expectations queued before the byte that closes each word goes out,
    // since the device strobes before the acknowledge bit ends
    task automatic write_frame(input logic [6:0] a, input logic [7:0] sub, input logic exp_ack);
        acs_pkg::acs_wr_s e;
        logic             ack;
        logic [31:0]      w;
        w = 32'h0000_0000;
        i_master.start_cond();
        i_master.wr_byte({a, 1'b0}, ack);
        check(ack, exp_ack);
        if (ack === 1'b1) begin
            i_master.wr_byte(sub, ack);
            check(ack, 1'b1);
            for (int i = 0; i < dq.size(); i++) begin
                w = {w[23:0], dq[i]};
                if (i % 4 == 3 || i == dq.size() - 1) begin
                    e.sub    = sub + 8'(i / 4);
                    e.data   = w;
                    e.nbytes = 3'(i % 4 + 1);
                    ex.push_back(e);
                    if (i % 4 == 3 && e.sub != 8'hF8 && e.sub != 8'hF9) cx.push_back(w[25:0]);
                    w = 32'h0000_0000;
                end
                i_master.wr_byte(dq[i], ack);
                check(ack, 1'b1);
            end
        end
        i_master.stop_cond();
        if (sub < 8'hF8) begin
            check(wq.size(), ex.size());
            while (wq.size() > 0 && ex.size() > 0) check(wq.pop_front(), ex.pop_front());
        end
        wq.delete();
        ex.delete();
    endtask : write_frame

    // Read three bytes after a repeated start; the last one is not acknowledged
    task automatic read_frame(input logic [6:0] a, input logic [7:0] sub);
        logic       ack;
        logic [7:0] d;
        rd_val = 8'(xs());
        i_master.start_cond();
        i_master.wr_byte({a, 1'b0}, ack);
        i_master.wr_byte(sub, ack);
        i_master.start_cond();
        i_master.wr_byte({a, 1'b1}, ack);
        check(ack, 1'b1);
        for (int k = 0; k < 3; k++) begin
            i_master.get_byte(k == 2, d);
            check(d, rd_val);
            // New byte before the device samples it after the acknowledge falls
            rd_val = 8'(xs());
        end
        check(rd_sub, sub);
        check(rd_idx, 8'h02);
        i_master.stop_cond();
    endtask : read_frame

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] w;
        do_reset(1'b0);
        check(slave_addr, 7'h1A);
        // Words with sign and unused-bit corners, some slow, with a random tail
        for (int k = 0; k < 6; k++) begin
            w = xs();
            if (k == 0) w = 32'hFE7F_FFFF;
            if (k == 1) w = 32'h0200_0001;
            i_master.stretch = (k % 2) * 3;
            dq = {w[31:24], w[23:16], w[15:8], w[7:0]};
            for (int j = 0; j < 4 + k % 4; j++) dq.push_back(8'(xs()));
            write_frame(7'h1A, 8'(xs()) & 8'h7F, 1'b1);
        end
        i_master.stretch = 0;
        write_frame(7'h1B, 8'h20, 1'b0);
        read_frame(7'h1A, 8'h20);
        // Clock enable low: a frozen device must not answer at all
        ce_en = 1'b0;
        write_frame(7'h1A, 8'h20, 1'b0);
        ce_en = 1'b1;
        // Address change: refused unarmed, wrong key, right key, then adopted
        dq = {8'h00, 8'h00, 8'h00, 8'hD5};
        write_frame(7'h1A, 8'hF9, 1'b1);
        check(slave_addr, 7'h1A);
        dq = {8'h00, 8'hF9, 8'hA5, 8'hA4};
        write_frame(7'h1A, 8'hF8, 1'b1);
        check(addr_armed, 1'b0);
        dq[3] = 8'hA5;
        write_frame(7'h1A, 8'hF8, 1'b1);
        check(addr_armed, 1'b1);
        dq = {8'h00, 8'h00, 8'h00, 8'hD5};
        write_frame(7'h1A, 8'hF9, 1'b1);
        check(slave_addr, 7'h55);
        dq = {8'h12, 8'h34};
        write_frame(7'h1A, 8'h10, 1'b0);
        write_frame(7'h55, 8'h10, 1'b1);
        // Strap high across a second reset
        do_reset(1'b1);
        check(slave_addr, 7'h1B);
        dq = {8'hA1, 8'hB2, 8'hC3};
        write_frame(7'h1B, 8'h30, 1'b1);
        write_frame(7'h1A, 8'h30, 1'b0);
        check(cx.size(), 0);
        report_and_stop();
    end

    // Watchdog well beyond the expected run of some 9k cycles
    initial begin
        #3000000;
        num_errors++;
        report_and_stop();
    end
endmodule : acs_slave_bench
